// ### logic/ecs_device.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Control bit 7 low selects process mode
// - Bit 5 sets output when comparator off
// - Bit 4 presents falling edge capture
// - Bit 3 presents rising edge capture
// - Rising bit 2 presets counter from word
// - Bit 1 low enables workpiece measurement
// - Measurement captures counter on both edges
// - Bit 0 arms zero input capture once
// - Later zero pulses ignored until rearmed
// - Controller never mixes bit 0 with 3/4
// - Controller supplies control byte each cycle
// - Device returns eight bit status byte
// - Status bit 7 low acknowledges process mode
// - Status bit 2 acknowledges preset adopted
// - Rearm: clear bit 0, await ack, set
// - Set compare sets, reset compare clears output
module ecs_device (
	input  wire logic                        clock_i,
	input  wire logic                        rst_i,
	ecs_link_if.dev                          link,
	input  wire logic                        gate_pin_i,
	input  wire logic                        zero_pin_i,
	input  wire logic                        count_up_i,
	input  wire logic                        count_down_i,
	output logic                             cmp_out_o,
	output logic [ecs_pkg::DATA_W-1:0]       count_o
);
	// ==========================================
	// Helpers
	// Level changes only once stages two and three agree
	function automatic logic filt(input logic [1:0] s, input logic f);
		filt = (s[0] == s[1]) ? s[0] : f;
	endfunction

	// ==========================================
	// Sampled process output image
	logic [ecs_pkg::BYTE_W-1:0] ctl_r;
	logic [ecs_pkg::DATA_W-1:0] set_val_r;
	logic [ecs_pkg::DATA_W-1:0] rst_val_r;
	logic [1:0]                 xd_r;

	// Image taken only on the exchange strobe
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctl_r     <= ecs_pkg::CTRL_RST;
			set_val_r <= ecs_pkg::WORD_RST;
			rst_val_r <= ecs_pkg::WORD_RST;
		end else if (link.xfer) begin
			ctl_r     <= link.control_byte_one;
			set_val_r <= link.data_set;
			rst_val_r <= link.data_reset;
		end
	end

	// Exchange delay line for the status refresh
	always_ff @(posedge clock_i) begin
		if (rst_i)
			xd_r <= 2'h0;
		else
			xd_r <= {xd_r[0], link.xfer};
	end

	// ==========================================
	// Control decode
	wire proc_mode = ~ctl_r[ecs_pkg::CB_MODE];
	wire cmp_en    = ctl_r[ecs_pkg::CB_CMP_EN];
	wire man_lvl   = ctl_r[ecs_pkg::CB_MAN_OUT];
	wire rd_fall   = ctl_r[ecs_pkg::CB_RD_FALL];
	wire rd_rise   = ctl_r[ecs_pkg::CB_RD_RISE];
	wire meas_en   = ~ctl_r[ecs_pkg::CB_MEAS_N];
	wire zero_arm  = ctl_r[ecs_pkg::CB_ZERO_ARM];
	wire preset_b  = ctl_r[ecs_pkg::CB_PRESET];

	// ==========================================
	// Pin synchronisers
	logic [2:0] gate_sy_r;
	logic [2:0] zero_sy_r;
	logic       gate_flt_r;
	logic       zero_flt_r;
	logic       gate_prev_r;
	logic       zero_prev_r;

	// Three stages; first stage feeds only the second
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			gate_sy_r   <= 3'h0;
			zero_sy_r   <= 3'h0;
			gate_flt_r  <= 1'b0;
			zero_flt_r  <= 1'b0;
			gate_prev_r <= 1'b0;
			zero_prev_r <= 1'b0;
		end else begin
			gate_sy_r   <= {gate_sy_r[1:0], gate_pin_i};
			zero_sy_r   <= {zero_sy_r[1:0], zero_pin_i};
			gate_flt_r  <= filt(gate_sy_r[2:1], gate_flt_r);
			zero_flt_r  <= filt(zero_sy_r[2:1], zero_flt_r);
			gate_prev_r <= gate_flt_r;
			zero_prev_r <= zero_flt_r;
		end
	end

	wire gate_rise = gate_flt_r & ~gate_prev_r;
	wire gate_fall = ~gate_flt_r & gate_prev_r;
	wire zero_rise = zero_flt_r & ~zero_prev_r;

	// ==========================================
	// Counter and preset
	logic                       pre_prev_r;
	logic                       pre_ack_r;
	logic [ecs_pkg::DATA_W-1:0] count_r;

	// Edge of the preset bit, one cycle wide
	wire preset_go = proc_mode & preset_b & ~pre_prev_r;

	// Preset wins over counting in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pre_prev_r <= 1'b0;
			count_r    <= ecs_pkg::WORD_RST;
		end else begin
			pre_prev_r <= preset_b;
			if (preset_go)
				count_r <= set_val_r;
			else if (count_up_i & ~count_down_i)
				count_r <= count_r + 32'h00000001;
			else if (count_down_i & ~count_up_i)
				count_r <= count_r - 32'h00000001;
		end
	end

	// Ack held until the controller drops the preset bit
	always_ff @(posedge clock_i) begin
		if (rst_i)
			pre_ack_r <= 1'b0;
		else if (preset_go)
			pre_ack_r <= 1'b1;
		else if (~preset_b)
			pre_ack_r <= 1'b0;
	end

	// ==========================================
	// Workpiece measurement
	logic [ecs_pkg::DATA_W-1:0] rise_cap_r;
	logic [ecs_pkg::DATA_W-1:0] fall_cap_r;
	logic                       meas_done_r;

	// Rising edge starts, falling edge completes
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rise_cap_r  <= ecs_pkg::WORD_RST;
			fall_cap_r  <= ecs_pkg::WORD_RST;
			meas_done_r <= 1'b0;
		end else if (proc_mode & meas_en) begin
			if (gate_rise) begin
				rise_cap_r  <= count_r;
				meas_done_r <= 1'b0;
			end else if (gate_fall) begin
				fall_cap_r  <= count_r;
				meas_done_r <= 1'b1;
			end
		end else if (~meas_en) begin
			meas_done_r <= 1'b0;
		end
	end

	// ==========================================
	// Zero input latch
	logic [ecs_pkg::DATA_W-1:0] zero_cap_r;
	logic                       zero_valid_r;

	// Set needs the arm bit, clear needs it low: never both
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			zero_cap_r   <= ecs_pkg::WORD_RST;
			zero_valid_r <= 1'b0;
		end else if (~zero_arm) begin
			zero_valid_r <= 1'b0;
		end else if (proc_mode & zero_rise & ~zero_valid_r) begin
			zero_cap_r   <= count_r;
			zero_valid_r <= 1'b1;
		end
	end

	// ==========================================
	// Output stage
	logic out_r;

	// Register mode freezes the output at its last level
	always_ff @(posedge clock_i) begin
		if (rst_i)
			out_r <= 1'b0;
		else if (proc_mode) begin
			if (cmp_en) begin
				if (count_r == set_val_r)
					out_r <= 1'b1;
				else if (count_r == rst_val_r)
					out_r <= 1'b0;
			end else
				out_r <= man_lvl;
		end
	end

	// ==========================================
	// Process input image
	logic [ecs_pkg::BYTE_W-1:0] status_r;
	logic [ecs_pkg::DATA_W-1:0] din_r;
	logic [ecs_pkg::DATA_W-1:0] latch_r;
	logic                       stat_vld_r;
	logic [ecs_pkg::BYTE_W-1:0] stat_nxt;
	logic [ecs_pkg::DATA_W-1:0] din_nxt;

	// Status byte layout
	assign stat_nxt[ecs_pkg::SB_MODE]       = ctl_r[ecs_pkg::CB_MODE];
	assign stat_nxt[ecs_pkg::SB_RSVD]       = 1'b0;
	assign stat_nxt[ecs_pkg::SB_OUT]        = out_r;
	assign stat_nxt[ecs_pkg::SB_GATE]       = gate_flt_r;
	assign stat_nxt[ecs_pkg::SB_ZERO]       = zero_flt_r;
	assign stat_nxt[ecs_pkg::SB_PRE_ACK]    = pre_ack_r;
	assign stat_nxt[ecs_pkg::SB_MEAS_DONE]  = meas_done_r;
	assign stat_nxt[ecs_pkg::SB_ZERO_VALID] = zero_valid_r;

	// Rising capture selected before falling if both asked
	assign din_nxt = rd_rise ? rise_cap_r :
			 rd_fall ? fall_cap_r :
			 count_r;

	// Two cycles after the strobe so acks track the new byte
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			status_r   <= ecs_pkg::STAT_RST;
			din_r      <= ecs_pkg::WORD_RST;
			latch_r    <= ecs_pkg::WORD_RST;
			stat_vld_r <= 1'b0;
		end else begin
			stat_vld_r <= xd_r[1];
			if (xd_r[1]) begin
				status_r <= stat_nxt;
				if (proc_mode) begin
					din_r   <= din_nxt;
					latch_r <= zero_cap_r;
				end
			end
		end
	end

	assign link.status_byte_one = status_r;
	assign link.data_in_main    = din_r;
	assign link.data_in_latch   = latch_r;
	assign link.status_valid    = stat_vld_r;
	assign cmp_out_o            = out_r;
	assign count_o              = count_r;
endmodule
`default_nettype wire

// ### logic/ecs_pkg.sv
`default_nettype none
package ecs_pkg;
	// ==========================================
	// Widths
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 8;
	localparam int IRQ_W  = 3;

	// ==========================================
	// Control byte one bit positions
	localparam int CB_MODE     = 7;
	localparam int CB_CMP_EN   = 6;
	localparam int CB_MAN_OUT  = 5;
	localparam int CB_RD_FALL  = 4;
	localparam int CB_RD_RISE  = 3;
	localparam int CB_PRESET   = 2;
	localparam int CB_MEAS_N   = 1;
	localparam int CB_ZERO_ARM = 0;

	// ==========================================
	// Status byte one bit positions
	localparam int SB_MODE       = 7;
	localparam int SB_RSVD       = 6;
	localparam int SB_OUT        = 5;
	localparam int SB_GATE       = 4;
	localparam int SB_ZERO       = 3;
	localparam int SB_PRE_ACK    = 2;
	localparam int SB_MEAS_DONE  = 1;
	localparam int SB_ZERO_VALID = 0;

	// ==========================================
	// Reset values
	localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
	localparam logic [BYTE_W-1:0] STAT_RST = 8'h00;
	localparam logic [DATA_W-1:0] WORD_RST = 32'h00000000;
	localparam logic [IRQ_W-1:0]  IRQ_RST  = 3'h0;

	// ==========================================
	// Controller register indices
	localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SET     = 8'h01;
	localparam logic [ADDR_W-1:0] REG_RESET   = 8'h02;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h03;
	localparam logic [ADDR_W-1:0] REG_DIN     = 8'h04;
	localparam logic [ADDR_W-1:0] REG_LATCH   = 8'h05;
	localparam logic [ADDR_W-1:0] REG_IRQ_ST  = 8'h06;
	localparam logic [ADDR_W-1:0] REG_IRQ_MSK = 8'h07;

	// ==========================================
	// Interrupt bits
	localparam int IRQ_ZERO = 0;
	localparam int IRQ_MEAS = 1;
	localparam int IRQ_PRE  = 2;

	// ==========================================
	// Exchange cycle timing
	// One exchange per microsecond: 125 clocks of 8 ns
	localparam int CLK_PS     = 8000;
	localparam int CYCLE_US   = 1;
	localparam int CYCLE_CLKS = (CYCLE_US * 1000000) / CLK_PS;
endpackage
`default_nettype wire

// ### logic/ecs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Process image link between controller and device
interface ecs_link_if;
	logic                              xfer;
	logic [ecs_pkg::BYTE_W-1:0]        control_byte_one;
	logic [ecs_pkg::DATA_W-1:0]        data_set;
	logic [ecs_pkg::DATA_W-1:0]        data_reset;
	logic                              status_valid;
	logic [ecs_pkg::BYTE_W-1:0]        status_byte_one;
	logic [ecs_pkg::DATA_W-1:0]        data_in_main;
	logic [ecs_pkg::DATA_W-1:0]        data_in_latch;

	modport ctrl (
		output xfer,
		output control_byte_one,
		output data_set,
		output data_reset,
		input  status_valid,
		input  status_byte_one,
		input  data_in_main,
		input  data_in_latch
	);

	modport dev (
		input  xfer,
		input  control_byte_one,
		input  data_set,
		input  data_reset,
		output status_valid,
		output status_byte_one,
		output data_in_main,
		output data_in_latch
	);
endinterface
`default_nettype wire

// ### logic/ecs_controller.sv
`timescale 1ns/1ps
`default_nettype none
module ecs_controller #(
	parameter int CYCLE_CLKS = ecs_pkg::CYCLE_CLKS
) (
	input  wire logic                        clock_i,
	input  wire logic                        rst_i,
	ecs_link_if.ctrl                         link,
	input  wire logic [ecs_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [ecs_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [ecs_pkg::DATA_W-1:0]  rdata_o,
	output logic                             irq_o
);
	// ==========================================
	// Exchange cycle divider
	logic [15:0] div_r;
	logic        xfer_r;
	wire         div_end = (div_r == 16'(CYCLE_CLKS - 1));

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			div_r  <= 16'h0000;
			xfer_r <= 1'b0;
		end else begin
			div_r  <= div_end ? 16'h0000 : div_r + 16'h0001;
			xfer_r <= div_end;
		end
	end

	// ==========================================
	// Software registers
	logic [ecs_pkg::BYTE_W-1:0] ctl_r;
	logic [ecs_pkg::DATA_W-1:0] set_r;
	logic [ecs_pkg::DATA_W-1:0] rstv_r;
	logic [ecs_pkg::BYTE_W-1:0] stat_r;
	logic [ecs_pkg::DATA_W-1:0] din_r;
	logic [ecs_pkg::DATA_W-1:0] latch_r;
	logic [ecs_pkg::IRQ_W-1:0]  irq_st_r;
	logic [ecs_pkg::IRQ_W-1:0]  irq_msk_r;
	logic [ecs_pkg::DATA_W-1:0] rdata_r;
	logic                       irq_r;

	wire wr_ctl = wr_i & (addr_i == ecs_pkg::REG_CTRL);
	wire wr_set = wr_i & (addr_i == ecs_pkg::REG_SET);
	wire wr_rst = wr_i & (addr_i == ecs_pkg::REG_RESET);
	wire wr_ist = wr_i & (addr_i == ecs_pkg::REG_IRQ_ST);
	wire wr_msk = wr_i & (addr_i == ecs_pkg::REG_IRQ_MSK);

	// Byte sanitised before it can reach the device
	wire [7:0] w_b    = wdata_i[7:0];
	wire       w_arm  = w_b[ecs_pkg::CB_ZERO_ARM];
	wire       re_arm = w_arm & ~ctl_r[ecs_pkg::CB_ZERO_ARM]
		& stat_r[ecs_pkg::SB_ZERO_VALID];
	wire [7:0] ctl_nxt = {1'b0,
		w_b[6:5],
		w_b[4:3] & {2{~w_arm}},
		w_b[2:1],
		w_arm & ~re_arm};

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctl_r  <= ecs_pkg::CTRL_RST;
			set_r  <= ecs_pkg::WORD_RST;
			rstv_r <= ecs_pkg::WORD_RST;
		end else begin
			if (wr_ctl)
				ctl_r <= ctl_nxt;
			if (wr_set)
				set_r <= wdata_i;
			if (wr_rst)
				rstv_r <= wdata_i;
		end
	end

	// ==========================================
	// Input image capture and interrupts
	wire [2:0] ev = {stat_r[ecs_pkg::SB_PRE_ACK], stat_r[ecs_pkg::SB_MEAS_DONE],
		stat_r[ecs_pkg::SB_ZERO_VALID]};
	wire [2:0] ev_new = {link.status_byte_one[ecs_pkg::SB_PRE_ACK],
		link.status_byte_one[ecs_pkg::SB_MEAS_DONE],
		link.status_byte_one[ecs_pkg::SB_ZERO_VALID]};
	wire [2:0] ev_set = link.status_valid ? (ev_new & ~ev) : 3'h0;
	// Set wins over a clear in the same cycle
	wire [2:0] ist_nxt = (irq_st_r & ~(wr_ist ? wdata_i[2:0] : 3'h0)) | ev_set;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stat_r    <= ecs_pkg::STAT_RST;
			din_r     <= ecs_pkg::WORD_RST;
			latch_r   <= ecs_pkg::WORD_RST;
			irq_st_r  <= ecs_pkg::IRQ_RST;
			irq_msk_r <= ecs_pkg::IRQ_RST;
			irq_r     <= 1'b0;
		end else begin
			if (link.status_valid) begin
				stat_r  <= link.status_byte_one;
				din_r   <= link.data_in_main;
				latch_r <= link.data_in_latch;
			end
			if (wr_msk)
				irq_msk_r <= wdata_i[2:0];
			irq_st_r <= ist_nxt;
			irq_r    <= |(ist_nxt & (wr_msk ? wdata_i[2:0] : irq_msk_r));
		end
	end

	// ==========================================
	// Read path; unmapped indices read zero
	wire [31:0] rd_mux =
		(addr_i == ecs_pkg::REG_CTRL)    ? {24'h000000, ctl_r} :
		(addr_i == ecs_pkg::REG_SET)     ? set_r :
		(addr_i == ecs_pkg::REG_RESET)   ? rstv_r :
		(addr_i == ecs_pkg::REG_STATUS)  ? {24'h000000, stat_r} :
		(addr_i == ecs_pkg::REG_DIN)     ? din_r :
		(addr_i == ecs_pkg::REG_LATCH)   ? latch_r :
		(addr_i == ecs_pkg::REG_IRQ_ST)  ? {29'h00000000, irq_st_r} :
		(addr_i == ecs_pkg::REG_IRQ_MSK) ? {29'h00000000, irq_msk_r} :
		32'h00000000;

	always_ff @(posedge clock_i) begin
		if (rst_i)
			rdata_r <= ecs_pkg::WORD_RST;
		else if (rd_i)
			rdata_r <= rd_mux;
	end

	assign link.xfer             = xfer_r;
	assign link.control_byte_one = ctl_r;
	assign link.data_set         = set_r;
	assign link.data_reset       = rstv_r;
	assign rdata_o               = rdata_r;
	assign irq_o                 = irq_r;
endmodule
`default_nettype wire

// ### tb/ecs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Link checker: watches the process image wires
module ecs_properties (
	input wire logic                       clock_i,
	input wire logic                       rst_i,
	input wire logic                       xfer,
	input wire logic [ecs_pkg::BYTE_W-1:0] control_byte_one,
	input wire logic [ecs_pkg::DATA_W-1:0] data_set,
	input wire logic [ecs_pkg::DATA_W-1:0] data_reset,
	input wire logic                       status_valid,
	input wire logic [ecs_pkg::BYTE_W-1:0] status_byte_one,
	input wire logic [ecs_pkg::DATA_W-1:0] data_in_main,
	input wire logic [ecs_pkg::DATA_W-1:0] data_in_latch
);
	default clocking dc @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// Exchange timing; status looks back three cycles to its xfer
	chk_xfer_answer: assert property (xfer |-> ##3 status_valid)
		else $error("exchange got no status");
	chk_valid_cause: assert property (status_valid |-> $past(xfer, 3))
		else $error("status without exchange");
	chk_image_stands: assert property (!status_valid |->
		$stable(status_byte_one) && $stable(data_in_main))
		else $error("image changed between exchanges");
	// ==========================================
	// Control byte as sent
	chk_mode_ctrl: assert property (!control_byte_one[7])
		else $error("register mode requested");
	chk_zero_exclusive: assert property (control_byte_one[0]
		|-> control_byte_one[4:3] == 2'h0)
		else $error("zero arm mixed with edge reads");
	// ==========================================
	// Status byte against the control byte of its exchange
	chk_mode_echo: assert property (status_valid
		|-> !status_byte_one[7])
		else $error("mode echo wrong");
	chk_rsvd_zero: assert property (status_valid
		|-> !status_byte_one[6])
		else $error("reserved status bit set");
	chk_preset_ack: assert property (status_valid
		&& status_byte_one[2]
		|-> $past(control_byte_one[2], 3))
		else $error("preset ack without preset");
	chk_zero_armed: assert property (status_valid
		&& status_byte_one[0]
		|-> $past(control_byte_one[0], 3))
		else $error("zero valid while disarmed");
	chk_meas_gate: assert property (status_valid
		&& status_byte_one[1]
		|-> !$past(control_byte_one[1], 3))
		else $error("done while measurement off");
	chk_manual_out: assert property (status_valid
		&& !$past(control_byte_one[6], 3)
		|-> status_byte_one[5] == $past(control_byte_one[5], 3))
		else $error("manual output not followed");
	// Main scenarios reached
	cover property (status_valid && status_byte_one[2]);
	cover property (status_valid && status_byte_one[1]);
	cover property (status_valid && status_byte_one[0]);
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock_i = 1'b0;
	logic        rst_i   = 1'b1;
	logic [7:0]  addr    = 8'h00;
	logic [31:0] wdata   = 32'h00000000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        gate    = 1'b0;
	logic        zero    = 1'b0;
	logic        up      = 1'b0;
	logic        dn      = 1'b0;
	logic [31:0] rdata, count, cnt, rv, p, c1;
	logic        irq, cmp;
	int          err_count  = 0;
	int          n_compared = 0;
	// ==========================================
	// Two ends joined across one link
	ecs_link_if link_bus ();
	ecs_controller #(.CYCLE_CLKS(8)) ecs_controller_i (.clock_i(clock_i),
		.rst_i(rst_i), .link(link_bus), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
	ecs_device ecs_device_i (.clock_i(clock_i), .rst_i(rst_i),
		.link(link_bus), .gate_pin_i(gate), .zero_pin_i(zero),
		.count_up_i(up), .count_down_i(dn), .cmp_out_o(cmp),
		.count_o(count));
	ecs_properties ecs_properties_i (.clock_i(clock_i), .rst_i(rst_i),
		.xfer(link_bus.xfer), .control_byte_one(link_bus.control_byte_one),
		.data_set(link_bus.data_set), .data_reset(link_bus.data_reset),
		.status_valid(link_bus.status_valid),
		.status_byte_one(link_bus.status_byte_one),
		.data_in_main(link_bus.data_in_main),
		.data_in_latch(link_bus.data_in_latch));
	// 125 MHz
	always #4 clock_i = ~clock_i;
	// ==========================================
	// Register port and pin helpers
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask
	// Read data stands from the cycle after the strobe until the next read
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [31:0] m, e);
		rd_reg(a, rv);
		check(nm, rv & m, e);
	endtask
	task automatic give_verdict;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bounded wait for n status refreshes
	task automatic wait_ex(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(posedge clock_i);
				k++;
			end while (link_bus.status_valid !== 1'b1 && k < 40);
			if (k >= 40) begin
				err_count++;
				give_verdict();
			end
		end
	endtask
	// Counter steps tracked in cnt for the expectations
	task automatic step(input logic u, input int n);
		repeat (n) begin
			@(posedge clock_i);
			up <= u;
			dn <= !u;
			cnt = u ? cnt + 32'h1 : cnt - 32'h1;
		end
		@(posedge clock_i);
		up <= 1'b0;
		dn <= 1'b0;
	endtask
	// Pins pass a filter, so each level is held well past it
	task automatic set_pin(input bit g, input logic v);
		@(posedge clock_i);
		if (g)
			gate <= v;
		else
			zero <= v;
		repeat (10) @(posedge clock_i);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		rd_chk("status", ecs_pkg::REG_STATUS, 32'hFF, 32'h00);
		rd_chk("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
		wr_reg(ecs_pkg::REG_CTRL, 32'h80);
		rd_chk("ctrl", ecs_pkg::REG_CTRL, 32'hFF, 32'h00);
		wr_reg(ecs_pkg::REG_CTRL, 32'h19);
		rd_chk("ctrl", ecs_pkg::REG_CTRL, 32'hFF, 32'h01);
		wr_reg(ecs_pkg::REG_CTRL, 32'h00);
		wr_reg(ecs_pkg::REG_IRQ_MSK, 32'h0);
		// Preset, its ack and the masked interrupt
		p = 32'h00001000;
		wr_reg(ecs_pkg::REG_SET, p);
		wr_reg(ecs_pkg::REG_CTRL, 32'h04);
		wait_ex(2);
		cnt = p;
		check("count", count, cnt);
		rd_chk("ack", ecs_pkg::REG_STATUS, 32'h04, 32'h04);
		rd_chk("irq_st", ecs_pkg::REG_IRQ_ST, 32'h04, 32'h04);
		check("irq", irq, 1'b0);
		wr_reg(ecs_pkg::REG_IRQ_MSK, 32'h4);
		repeat (2) @(posedge clock_i);
		#1 check("irq", irq, 1'b1);
		wr_reg(ecs_pkg::REG_IRQ_ST, 32'h4);
		repeat (2) @(posedge clock_i);
		#1 check("irq", irq, 1'b0);
		wr_reg(ecs_pkg::REG_CTRL, 32'h00);
		wait_ex(2);
		rd_chk("ack", ecs_pkg::REG_STATUS, 32'h04, 32'h00);
		// Comparator against manual level
		wr_reg(ecs_pkg::REG_SET, p + 32'h2);
		wr_reg(ecs_pkg::REG_RESET, p + 32'h4);
		step(1'b1, 2);
		repeat (4) @(posedge clock_i);
		check("out", cmp, 1'b0);
		wr_reg(ecs_pkg::REG_CTRL, 32'h40);
		wait_ex(2);
		check("out", cmp, 1'b1);
		step(1'b1, 2);
		repeat (4) @(posedge clock_i);
		check("out", cmp, 1'b0);
		wr_reg(ecs_pkg::REG_CTRL, 32'h60);
		wait_ex(2);
		check("out", cmp, 1'b0);
		step(1'b0, 1);
		wr_reg(ecs_pkg::REG_CTRL, 32'h20);
		wait_ex(2);
		check("out", cmp, 1'b1);
		rd_chk("st_out", ecs_pkg::REG_STATUS, 32'h20, 32'h20);
		// Workpiece measurement on both gate edges
		wr_reg(ecs_pkg::REG_CTRL, 32'h00);
		wait_ex(2);
		c1 = cnt;
		set_pin(1'b1, 1'b1);
		wait_ex(2);
		rd_chk("st_gate", ecs_pkg::REG_STATUS, 32'h10, 32'h10);
		step(1'b1, 3);
		set_pin(1'b1, 1'b0);
		wait_ex(2);
		rd_chk("done", ecs_pkg::REG_STATUS, 32'h02, 32'h02);
		wr_reg(ecs_pkg::REG_CTRL, 32'h08);
		wait_ex(2);
		rd_chk("din", ecs_pkg::REG_DIN, 32'hFFFFFFFF, c1);
		wr_reg(ecs_pkg::REG_CTRL, 32'h10);
		wait_ex(2);
		rd_chk("din", ecs_pkg::REG_DIN, 32'hFFFFFFFF, cnt);
		wr_reg(ecs_pkg::REG_CTRL, 32'h02);
		wait_ex(2);
		rd_chk("done", ecs_pkg::REG_STATUS, 32'h02, 32'h00);
		// Zero latch: first pulse only, then rearm handshake
		wr_reg(ecs_pkg::REG_CTRL, 32'h01);
		wait_ex(2);
		c1 = cnt;
		set_pin(1'b0, 1'b1);
		// Zero pin level shows in the status while it is held
		wait_ex(2);
		rd_chk("st_zero", ecs_pkg::REG_STATUS, 32'h08, 32'h08);
		set_pin(1'b0, 1'b0);
		wait_ex(2);
		rd_chk("latch", ecs_pkg::REG_LATCH, 32'hFFFFFFFF, c1);
		rd_chk("valid", ecs_pkg::REG_STATUS, 32'h09, 32'h01);
		step(1'b1, 1);
		set_pin(1'b0, 1'b1);
		set_pin(1'b0, 1'b0);
		wait_ex(2);
		rd_chk("latch", ecs_pkg::REG_LATCH, 32'hFFFFFFFF, c1);
		wr_reg(ecs_pkg::REG_CTRL, 32'h00);
		wr_reg(ecs_pkg::REG_CTRL, 32'h01);
		rd_chk("ctrl", ecs_pkg::REG_CTRL, 32'h01, 32'h00);
		wait_ex(2);
		wr_reg(ecs_pkg::REG_CTRL, 32'h01);
		wait_ex(2);
		c1 = cnt;
		set_pin(1'b0, 1'b1);
		set_pin(1'b0, 1'b0);
		wait_ex(2);
		rd_chk("latch", ecs_pkg::REG_LATCH, 32'hFFFFFFFF, c1);
		check("count", count, cnt);
		give_verdict();
	end
endmodule
`default_nettype wire
